// *** cz_pkg.sv ***
/*
 shared constants for the code-size custom instruction unit: opcodes,
 function codes, top-field codes, fixed registers, alignment masks and exception causes.
 assumes a risc-v style 32-bit instruction word and an xlen of 32 or 64.
*/
package cz_pkg;
   // major opcodes
   localparam logic [6:0] op_cust3        = 7'h7b;  // 1111011
   localparam logic [6:0] op_cust2        = 7'h5b;  // 1011011
   // funct3 codes
   localparam logic [2:0] f3_byte         = 3'h0;
   localparam logic [2:0] f3_half         = 3'h1;
   localparam logic [2:0] f3_word         = 3'h2;
   localparam logic [2:0] f3_dword        = 3'h3;
   localparam logic [2:0] f3_half_u       = 3'h5;
   localparam logic [2:0] f3_word_u       = 3'h6;
   localparam logic [2:0] f3_br_imm       = 3'h2;
   localparam logic [2:0] f3_misc         = 3'h1;
   localparam logic [2:0] f3_strbr        = 3'h3;
   // top-field codes
   localparam logic [3:0] top4_post_st    = 4'ha;   // 1010
   localparam logic [6:0] top7_zero_mask  = 7'h70;  // 1110000
   localparam logic [6:0] top7_first_nz   = 7'h71;  // 1110001
   localparam logic [1:0] top2_load_s     = 2'h0;
   localparam logic [1:0] top2_load_u     = 2'h1;
   localparam logic [1:0] top2_store      = 2'h2;
   localparam logic [1:0] top2_store_b    = 2'h3;
   // fixed registers
   localparam logic [4:0] reg_gp          = 5'h03;
   localparam logic [4:0] reg_diff        = 5'h1f;  // x31
   // alignment masks and byte values
   localparam logic [2:0] mask_rv32       = 3'h3;
   localparam logic [2:0] mask_rv64       = 3'h7;
   localparam logic [7:0] byte_zero       = 8'h00;
   localparam logic [7:0] byte_full       = 8'hff;
   // exception causes
   localparam logic [3:0] cause_illegal   = 4'h2;
   localparam logic [3:0] cause_st_misal  = 4'h6;
endpackage

// *** cz_unit.sv ***
/*
 code-size custom instruction unit: decodes one issued instruction per cycle,
 computes memory requests, register writes, next pc and exceptions.
 assumes the issue stage supplies rs1/rs2/gp values with the instruction and
 that the load-store unit returns load data later with its own writeback;
 this unit only issues the request and the extend mode for the load.
*/
// Contract
// RULE_01: post-increment dword store: 8 bytes at rs1, rv64
// RULE_02: post-increment store writes rs1 plus imm back
// RULE_03: misaligned raises unaligned, bad cases illegal
// RULE_04: gp byte load, signed or unsigned extension
// RULE_05: gp half load, imm shifted by one
// RULE_06: gp word load, unsigned form rv64 only
// RULE_07: gp dword load, imm shifted by three
// RULE_08: gp byte store, split immediate reassembled
// RULE_09: gp half/word/dword store, scaled immediate
// RULE_10: alignment branch when (rs1|rs2)&mask nonzero
// RULE_11: string branch on zero byte or mismatch
// RULE_12: zero-byte mask, chained byte by byte
// RULE_13: first nonzero byte from lsb, else zero
// RULE_14: branch if rs1 equals sign-extended imm
// RULE_15: undefined or rv64-only-on-rv32 is illegal
`timescale 1ns/1ps
module cz_unit
#(
   parameter int xlen = 64                       // 32 or 64
)
(
   input  wire logic            clk_in,          // 50 mhz core clock
   input  wire logic            reset_in,        // async, active high
   input  wire logic            valid_in,        // instruction issued
   input  wire logic [31:0]     instr_in,        // instruction word
   input  wire logic [xlen-1:0] pc_in,           // instruction address
   input  wire logic [xlen-1:0] rs1_in,          // rs1 value
   input  wire logic [xlen-1:0] rs2_in,          // rs2 value
   input  wire logic [xlen-1:0] gp_in,           // global pointer value
   output logic                 mem_req_out,     // memory request pulse
   output logic                 mem_we_out,      // 1 store, 0 load
   output logic [xlen-1:0]      mem_addr_out,    // byte address
   output logic [xlen-1:0]      mem_wdata_out,   // store data, low aligned
   output logic [1:0]           mem_size_out,    // log2 of byte count
   output logic                 mem_unsigned_out,// zero-extend load
   output logic [4:0]           load_rd_out,     // load destination
   output logic                 wb_en_out,       // register write pulse
   output logic [4:0]           wb_rd_out,       // write destination
   output logic [xlen-1:0]      wb_data_out,     // write value
   output logic                 br_taken_out,    // redirect pulse
   output logic [xlen-1:0]      next_pc_out,     // next pc
   output logic                 done_out,        // handled pulse
   output logic                 exc_out,         // exception pulse
   output logic [3:0]           exc_cause_out    // exception cause
);
   // elaboration check: only the two register widths are decoded
   if (xlen != 32 && xlen != 64)
   begin
      $error("xlen must be 32 or 64");
   end

   localparam int nbytes = xlen / 8;
   localparam logic rv64 = (xlen == 64);

   ////////////////////////////////////////////////////////////////////
   // helpers

   // sign-extend an 18-bit value to xlen
   function automatic logic [xlen-1:0] sext18(input logic [17:0] v);
      sext18 = {{(xlen-18){v[17]}}, v};
   endfunction

   // mask of bytes up to and including the first zero byte
   function automatic logic [xlen-1:0] nz_mask(input logic [xlen-1:0] v);
      logic run;
      run = 1'b1;
      nz_mask = '0;
      for (int i = 0; i < nbytes; i++)
      begin
         nz_mask[i*8 +: 8] = run ? cz_pkg::byte_full : cz_pkg::byte_zero;
         run = run && (v[i*8 +: 8] != cz_pkg::byte_zero);
      end
   endfunction

   // any zero byte within the register
   function automatic logic has_zero(input logic [xlen-1:0] v);
      has_zero = 1'b0;
      for (int i = 0; i < nbytes; i++)
         if (v[i*8 +: 8] == cz_pkg::byte_zero)
            has_zero = 1'b1;
   endfunction

   ////////////////////////////////////////////////////////////////////
   // decode fields
   logic [6:0]      opc;                         // major opcode
   logic [2:0]      f3;                          // funct3
   logic [4:0]      rd_f;                        // rd field
   logic [4:0]      rs1_f;                       // rs1 field
   logic [4:0]      rs2_f;                       // rs2 field
   assign opc   = instr_in[6:0];
   assign f3    = instr_in[14:12];
   assign rd_f  = instr_in[11:7];
   assign rs1_f = instr_in[19:15];
   assign rs2_f = instr_in[24:20];

   // immediates
   logic [10:0]     imm_post;                    // post-increment offset
   logic [17:0]     imm_ld_b;                    // gp byte load
   logic [17:0]     imm_ld_s;                    // gp scaled load field
   logic [17:0]     imm_st_b;                    // gp byte store
   logic [17:0]     imm_st_s;                    // gp scaled store field
   logic [17:0]     imm_br;                      // 13-bit branch offset
   logic [xlen-1:0] cimm;                        // immediate compare value
   assign imm_post  = {instr_in[27:25], instr_in[11:7], 3'h0};
   assign imm_ld_b  = {{2{instr_in[29]}}, instr_in[29:14]};
   assign imm_ld_s  = {{3{instr_in[29]}}, instr_in[29:15]};
   assign imm_st_b  = {{2{instr_in[29]}}, instr_in[29:25], instr_in[19:14], instr_in[11:7]};
   assign imm_st_s  = {{3{instr_in[29]}}, instr_in[29:25], instr_in[19:15], instr_in[11:7]};
   assign imm_br    = {{5{instr_in[31]}}, instr_in[31], instr_in[7], instr_in[30:25],
                       instr_in[11:8], 1'b0};
   assign cimm      = {{(xlen-5){instr_in[24]}}, instr_in[24:20]};

   ////////////////////////////////////////////////////////////////////
   // next-state computation
   logic            mem_req_d, mem_we_d, mem_uns_d, wb_en_d, br_d, done_d, exc_d;
   logic [xlen-1:0] mem_addr_d, mem_wdata_d, wb_data_d, next_pc_d;
   logic [1:0]      mem_size_d;
   logic [4:0]      load_rd_d, wb_rd_d;
   logic [3:0]      cause_d;

   always_comb
   begin
      logic            illegal;
      logic            taken;
      logic [xlen-1:0] diff;
      logic [xlen-1:0] am;
      illegal     = 1'b0;
      taken       = 1'b0;
      diff        = rs1_in - rs2_in;
      am          = rv64 ? xlen'(cz_pkg::mask_rv64) : xlen'(cz_pkg::mask_rv32);
      mem_req_d   = 1'b0;
      mem_we_d    = 1'b0;
      mem_uns_d   = 1'b0;
      mem_addr_d  = '0;
      mem_wdata_d = rs2_in;
      mem_size_d  = 2'h0;
      load_rd_d   = rd_f;
      wb_en_d     = 1'b0;
      wb_rd_d     = rd_f;
      wb_data_d   = '0;
      br_d        = 1'b0;
      done_d      = valid_in;
      cause_d     = cz_pkg::cause_illegal;
      if (opc == cz_pkg::op_cust3)
      begin
         if (f3 == cz_pkg::f3_misc && instr_in[31:28] == cz_pkg::top4_post_st)
         begin
            illegal     = !rv64;                                   // RULE_15
            mem_req_d   = 1'b1;                                    // RULE_01
            mem_we_d    = 1'b1;
            mem_size_d  = 2'h3;
            mem_addr_d  = rs1_in;
            wb_rd_d     = rs1_f;                                   // RULE_02
            wb_data_d   = rs1_in + xlen'(imm_post);                // RULE_02
            wb_en_d     = 1'b1;
            if (rs1_in[2:0] != 3'h0)                               // RULE_03
            begin
               illegal = 1'b1;
               cause_d = rv64 ? cz_pkg::cause_st_misal : cz_pkg::cause_illegal;
            end
         end
         else if (f3 == cz_pkg::f3_misc && instr_in[31:25] == cz_pkg::top7_zero_mask && rs2_f == 5'h0)
         begin
            wb_en_d   = 1'b1;
            wb_data_d = nz_mask(rs1_in);                           // RULE_12
         end
         else if (f3 == cz_pkg::f3_misc && instr_in[31:25] == cz_pkg::top7_first_nz && rs2_f == 5'h0)
         begin
            wb_en_d = 1'b1;
            for (int i = nbytes - 1; i >= 0; i--)                  // RULE_13
               if (rs1_in[i*8 +: 8] != cz_pkg::byte_zero)
                  wb_data_d = xlen'(rs1_in[i*8 +: 8]);
         end
         else if (f3 == cz_pkg::f3_strbr && !instr_in[31])
            taken = ((rs1_in | rs2_in) & am) != '0;               // RULE_10
         else if (f3 == cz_pkg::f3_strbr && instr_in[31])
         begin
            taken     = has_zero(rs1_in) || (rs1_in != rs2_in);    // RULE_11
            wb_en_d   = 1'b1;
            wb_rd_d   = cz_pkg::reg_diff;                          // RULE_11
            wb_data_d = diff;
         end
         else if (f3 == cz_pkg::f3_br_imm)
            taken = (rs1_in == cimm);                              // RULE_14
         else
            illegal = 1'b1;                                        // RULE_15
      end
      else if (opc == cz_pkg::op_cust2)
      begin
         mem_req_d = 1'b1;
         if (instr_in[31:30] == cz_pkg::top2_store_b && f3[1:0] == 2'h0)
         begin
            mem_we_d   = 1'b1;                                     // RULE_08
            mem_addr_d = gp_in + sext18(imm_st_b);
         end
         else if (instr_in[31:30] == cz_pkg::top2_store && f3 != cz_pkg::f3_byte && f3[2] == 1'b0)
         begin
            mem_we_d   = 1'b1;                                     // RULE_09
            mem_size_d = f3[1:0];
            mem_addr_d = gp_in + (sext18(imm_st_s) << f3[1:0]);
            illegal    = (f3 == cz_pkg::f3_dword) && !rv64;        // RULE_15
         end
         else if (instr_in[31:30] != cz_pkg::top2_store && instr_in[31:30] != cz_pkg::top2_store_b
                  && f3[1:0] == 2'h0)
         begin
            mem_uns_d  = (instr_in[31:30] == cz_pkg::top2_load_u); // RULE_04
            mem_addr_d = gp_in + sext18(imm_ld_b);                 // RULE_04
         end
         else if (instr_in[31:30] == cz_pkg::top2_load_s && f3 != cz_pkg::f3_byte)
         begin
            mem_size_d = f3[1:0];                                  // RULE_05
            mem_uns_d  = f3[2];                                    // RULE_06
            mem_addr_d = gp_in + (sext18(imm_ld_s) << f3[1:0]);    // RULE_07
            if (f3 == 3'h4 || f3 == 3'h7 || (f3 == cz_pkg::f3_word_u && !rv64)
                || (f3 == cz_pkg::f3_dword && !rv64))
               illegal = 1'b1;                                     // RULE_15
         end
         else
            illegal = 1'b1;                                        // RULE_15
      end
      else
      begin
         // another unit owns this opcode: trapping it here would kill ordinary code
         done_d  = 1'b0;
      end
      next_pc_d = taken ? pc_in + sext18(imm_br) : pc_in + xlen'(4);
      br_d      = taken;
      if (!valid_in || illegal)
      begin
         mem_req_d = 1'b0;
         wb_en_d   = 1'b0;
         br_d      = 1'b0;
      end
      exc_d = valid_in && illegal;                                 // RULE_03
   end

   ////////////////////////////////////////////////////////////////////
   // output registers: all outputs come straight from flip-flops
   always_ff @(posedge clk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         mem_req_out      <= 1'b0;
         mem_we_out       <= 1'b0;
         mem_addr_out     <= '0;
         mem_wdata_out    <= '0;
         mem_size_out     <= 2'h0;
         mem_unsigned_out <= 1'b0;
         load_rd_out      <= 5'h0;
         wb_en_out        <= 1'b0;
         wb_rd_out        <= 5'h0;
         wb_data_out      <= '0;
         br_taken_out     <= 1'b0;
         next_pc_out      <= '0;
         done_out         <= 1'b0;
         exc_out          <= 1'b0;
         exc_cause_out    <= 4'h0;
      end
      else
      begin
         mem_req_out      <= mem_req_d;
         mem_we_out       <= mem_we_d;
         mem_addr_out     <= mem_addr_d;
         mem_wdata_out    <= mem_wdata_d;
         mem_size_out     <= mem_size_d;
         mem_unsigned_out <= mem_uns_d;
         load_rd_out      <= load_rd_d;
         wb_en_out        <= wb_en_d;
         wb_rd_out        <= wb_rd_d;
         wb_data_out      <= wb_data_d;
         br_taken_out     <= br_d;
         next_pc_out      <= next_pc_d;
         done_out         <= done_d;
         exc_out          <= exc_d;
         exc_cause_out    <= cause_d;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // checks
   a_post_writeback: assert property (@(posedge clk_in) disable iff (reset_in) // RULE_02
      (valid_in && instr_in[6:0] == cz_pkg::op_cust3 && instr_in[14:12] == 3'h1
       && instr_in[31:28] == 4'ha && rv64 && rs1_in[2:0] == 3'h0)
      |=> (wb_en_out && mem_req_out && mem_we_out && mem_size_out == 2'h3
           && wb_data_out == $past(rs1_in) + xlen'($past(imm_post))))
      else $error("post-increment store writeback wrong");
   a_misal_exc: assert property (@(posedge clk_in) disable iff (reset_in) // RULE_03
      (valid_in && instr_in[6:0] == cz_pkg::op_cust3 && instr_in[14:12] == 3'h1
       && instr_in[31:28] == 4'ha && rs1_in[2:0] != 3'h0)
      |=> (exc_out && !mem_req_out))
      else $error("misaligned store not trapped");
   a_illegal_quiet: assert property (@(posedge clk_in) disable iff (reset_in) // RULE_15
      exc_out |-> (!wb_en_out && !br_taken_out && !mem_req_out))
      else $error("exception with side effect");
   a_imm_branch_target: assert property (@(posedge clk_in) disable iff (reset_in) // RULE_14
      (valid_in && instr_in[6:0] == cz_pkg::op_cust3 && instr_in[14:12] == 3'h2)
      |=> (br_taken_out == ($past(rs1_in) == $past(cimm))
           && next_pc_out == (br_taken_out ? $past(pc_in) + sext18($past(imm_br))
                                           : $past(pc_in) + xlen'(4))))
      else $error("immediate branch target wrong");
   a_strbr_x31: assert property (@(posedge clk_in) disable iff (reset_in) // RULE_11
      (valid_in && instr_in[6:0] == cz_pkg::op_cust3 && instr_in[14:12] == 3'h3 && instr_in[31])
      |=> (wb_en_out && wb_rd_out == 5'h1f && wb_data_out == $past(rs1_in) - $past(rs2_in)))
      else $error("string branch difference not written");
   a_gp_byte_load: assert property (@(posedge clk_in) disable iff (reset_in) // RULE_04
      (valid_in && instr_in[6:0] == cz_pkg::op_cust2 && instr_in[13:12] == 2'h0
       && instr_in[31:30] == 2'h1)
      |=> (mem_req_out && !mem_we_out && mem_unsigned_out && mem_size_out == 2'h0))
      else $error("gp byte load decode wrong");
   a_mask_byte0: assert property (@(posedge clk_in) disable iff (reset_in) // RULE_12
      (valid_in && instr_in[6:0] == cz_pkg::op_cust3 && instr_in[14:12] == 3'h1
       && instr_in[31:25] == 7'h70 && instr_in[24:20] == 5'h0)
      |=> (wb_en_out && wb_data_out[7:0] == 8'hff))
      else $error("zero-byte mask byte 0 not full");
   a_align_branch: assert property (@(posedge clk_in) disable iff (reset_in) // RULE_10
      (valid_in && instr_in[6:0] == cz_pkg::op_cust3 && instr_in[14:12] == 3'h3 && !instr_in[31]
       && ((rs1_in | rs2_in) & xlen'(7)) == '0)
      |=> (!br_taken_out && next_pc_out == $past(pc_in) + xlen'(4)))
      else $error("aligned operands branched");
endmodule

// *** cz_mem_model.sv ***
/*
 memory-side stand-in for the code-size unit: counts every store and keeps the address and data of the last one.
 assumes requests are one-cycle pulses that are sampled on the rising edge of clk_in.
*/
`timescale 1ns/1ps
module cz_mem_model
(
   input  wire logic        clk_in,     // core clock
   input  wire logic        req_in,     // request pulse
   input  wire logic        we_in,      // store when high
   input  wire logic [63:0] addr_in,    // byte address
   input  wire logic [63:0] wdata_in,   // store data, low aligned
   input  wire logic [1:0]  size_in,    // log2 of byte count
   output logic      [31:0] stores_out, // number of stores taken
   output logic      [63:0] addr_out,   // address of the last store
   output logic      [63:0] data_out    // bytes of the last store, upper lanes zero
);
   ////////////////////////////////////////////////////////////////////////////
   // only the lanes that the size covers reach memory, as a real array would do
   initial stores_out = 32'h0;
   always @(posedge clk_in)
   begin
      if (req_in && we_in)
      begin
         stores_out <= stores_out + 32'h1;
         addr_out   <= addr_in;
         data_out   <= wdata_in & ~(64'hffffffffffffffff << (64'h8 << size_in));
      end
   end
endmodule

// *** codesize_custom_mem_branch_ops_tb.sv ***
/*
 self-checking bench for the code-size custom instruction unit, with xlen 64.
 assumes a one-cycle answer to every issued instruction and fixed pc and gp values.
*/
`timescale 1ns/1ps
module codesize_custom_mem_branch_ops_tb;
   localparam logic [63:0] pc0 = 64'h4000;   // pc of every instruction
   localparam logic [63:0] gp0 = 64'h20000;  // global pointer value
   logic        clk_in = 1'b0, reset_in = 1'b1, valid_in = 1'b0;
   logic [31:0] instr_in = 32'h0;            // instruction word
   logic [63:0] rs1_in = 64'h0, rs2_in = 64'h0, pc_in = pc0, gp_in = gp0;
   logic        mem_req_out, mem_we_out, mem_unsigned_out, wb_en_out, br_taken_out, done_out, exc_out;
   logic [63:0] mem_addr_out, mem_wdata_out, wb_data_out, next_pc_out, st_addr, st_data;
   logic [1:0]  mem_size_out;                // log2 of byte count
   logic [4:0]  load_rd_out, wb_rd_out;      // destinations
   logic [3:0]  exc_cause_out;               // exception cause
   logic [31:0] st_count;                    // stores seen by the memory
   int          bad_count = 0, comparisons = 0;
   always #10 clk_in = ~clk_in;
   cz_unit #(.xlen(64)) cz_unit_i (.clk_in, .reset_in, .valid_in, .instr_in, .pc_in, .rs1_in, .rs2_in,
      .gp_in, .mem_req_out, .mem_we_out, .mem_addr_out, .mem_wdata_out, .mem_size_out, .mem_unsigned_out,
      .load_rd_out, .wb_en_out, .wb_rd_out, .wb_data_out, .br_taken_out, .next_pc_out, .done_out, .exc_out,
      .exc_cause_out);
   cz_mem_model cz_mem_model_i (.clk_in(clk_in), .req_in(mem_req_out), .we_in(mem_we_out),
      .addr_in(mem_addr_out), .wdata_in(mem_wdata_out), .size_in(mem_size_out), .stores_out(st_count),
      .addr_out(st_addr), .data_out(st_data));
   ////////////////////////////////////////////////////////////////////////////
   // compare, issue and closing tasks; every task starts and ends at a falling edge
   task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
      comparisons++;
      if (got !== exp)
      begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic flags(input logic [4:0] exp);
      chk("req_wb_br_exc_done", {59'h0, exp}, {59'h0, mem_req_out, wb_en_out, br_taken_out, exc_out, done_out});
   endtask
   // valid stays high so that calls in a row issue back to back
   task automatic issue(input logic [31:0] ins, input logic [63:0] a, input logic [63:0] b);
      valid_in = 1'b1;
      instr_in = ins;
      rs1_in   = a;
      rs2_in   = b;
      @(negedge clk_in);
   endtask
   task automatic idle;
      valid_in = 1'b0;
      @(negedge clk_in);
   endtask
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // expected zero-byte mask, chained lane by lane from the low byte
   function automatic logic [63:0] mask_of(input logic [63:0] v);
      logic [63:0] m;
      m[7:0] = 8'hff;
      for (int k = 1; k < 8; k++)
         m[8*k +: 8] = (v[8*k-8 +: 8] == 8'h00) ? 8'h00 : m[8*k-8 +: 8];
      return m;
   endfunction
   function automatic logic [63:0] first_nz(input logic [63:0] v);
      for (int k = 7; k >= 0; k--)
         if (v[8*k +: 8] != 8'h00)
            first_nz = {56'h0, v[8*k +: 8]};
      if (v == 64'h0)
         first_nz = 64'h0;
   endfunction
   ////////////////////////////////////////////////////////////////////////////
   // post-increment store, then a misaligned one right behind it
   task automatic t_post_store;
      logic [31:0] ins;
      ins = {4'ha, 3'h0, 5'd7, 5'd9, 3'h1, 5'b10101, 7'h7b};
      issue(ins, 64'h1000, 64'h1122334455667788);
      flags(5'b11001);
      chk("we", 64'h1, {63'h0, mem_we_out});
      chk("addr", 64'h1000, mem_addr_out);
      chk("size", 64'h3, {62'h0, mem_size_out});
      chk("wb_rd", 64'h9, {59'h0, wb_rd_out});
      chk("wb_data", 64'h10a8, wb_data_out);
      chk("next_pc", pc0 + 64'h4, next_pc_out);
      issue(ins, 64'h1004, 64'h0);
      chk("stored", 64'h1122334455667788, st_data);
      chk("stored_addr", 64'h1000, st_addr);
      flags(5'b00011);
      chk("cause", 64'h6, {60'h0, exc_cause_out});
      idle();
      chk("store_count", 64'h1, {32'h0, st_count});
      $display("test post_store done");
   endtask
   // every gp load form from a table, then a negative offset and an undefined form
   task automatic t_gp_loads;
      logic [2:0] f3s [7] = '{3'h0, 3'h0, 3'h1, 3'h5, 3'h2, 3'h6, 3'h3};
      logic [1:0] szs [7] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3};
      logic [14:0] f = 15'h1234;
      for (int i = 0; i < 7; i++)
      begin
         issue({1'b0, i == 1, f, f3s[i], 5'd5, 7'h5b}, 64'h0, 64'h0);
         flags(5'b10001);
         chk("we", 64'h0, {63'h0, mem_we_out});
         chk("addr", gp0 + (szs[i] == 2'h0 ? {f, f3s[i][2]} : ({49'h0, f} << szs[i])), mem_addr_out);
         chk("size", {62'h0, szs[i]}, {62'h0, mem_size_out});
         chk("unsigned", {63'h0, i == 1 || f3s[i][2]}, {63'h0, mem_unsigned_out});
         chk("load_rd", 64'h5, {59'h0, load_rd_out});
      end
      issue({2'b00, 16'h8000, 2'b00, 5'd5, 7'h5b}, 64'h0, 64'h0);
      chk("addr", gp0 - 64'h8000, mem_addr_out);
      issue({2'b00, 15'h0, 3'h7, 5'd5, 7'h5b}, 64'h0, 64'h0);
      flags(5'b00011);
      chk("cause", 64'h2, {60'h0, exc_cause_out});
      idle();
      $display("test gp_loads done");
   endtask
   // byte store from three split fields, then scaled half, word and dword stores
   task automatic t_gp_stores;
      logic [15:0] u = 16'h2345;
      logic [14:0] v = 15'h1357;
      issue({2'b11, u[15:11], 5'd6, u[10:5], 2'b00, u[4:0], 7'h5b}, 64'h0, 64'h8877665544332211);
      flags(5'b10001);
      chk("addr", gp0 + 64'h2345, mem_addr_out);
      idle();
      chk("stored", 64'h11, st_data);
      for (int k = 1; k < 4; k++)
      begin
         issue({2'b10, v[14:10], 5'd6, v[9:5], k[2:0], v[4:0], 7'h5b}, 64'h0, 64'h8877665544332211);
         chk("we", 64'h1, {63'h0, mem_we_out});
         chk("addr", gp0 + ({49'h0, v} << k), mem_addr_out);
         chk("size", {62'h0, k[1:0]}, {62'h0, mem_size_out});
         idle();
         chk("stored", 64'h8877665544332211 & ~(64'hffffffffffffffff << (8 << k)), st_data);
         chk("stored_addr", gp0 + ({49'h0, v} << k), st_addr);
      end
      $display("test gp_stores done");
   endtask
   // alignment, string and immediate branches, taken and not taken
   task automatic t_branches;
      logic [63:0] ra [4] = '{64'h1004, 64'h1000, 64'h1000, 64'h1008};
      logic [63:0] rb [4] = '{64'h0, 64'h2000, 64'h2001, 64'h10};
      logic [63:0] sa [3] = '{64'h1122334455667788, 64'h1122334400667788, 64'h88};
      logic [63:0] sb [3] = '{64'h1122334455667788, 64'h1122334400667788, 64'h80};
      for (int i = 0; i < 4; i++)
      begin
         issue({7'h02, 5'd2, 5'd1, 3'h3, 5'h0, 7'h7b}, ra[i], rb[i]);
         chk("taken", {63'h0, i != 1 && i != 3}, {63'h0, br_taken_out});
         chk("next_pc", pc0 + ((i != 1 && i != 3) ? 64'h40 : 64'h4), next_pc_out);
      end
      for (int i = 0; i < 3; i++)
      begin
         issue({7'h40, 5'd2, 5'd1, 3'h3, 5'h0, 7'h7b}, sa[i], sb[i]);
         chk("taken", {63'h0, i != 0}, {63'h0, br_taken_out});
         chk("wb_rd", 64'h1f, {59'h0, wb_rd_out});
         chk("wb_data", sa[i] - sb[i], wb_data_out);
         // offset field is bit 12 alone, so a taken branch lands 0x1000 below
         chk("next_pc", (i != 0) ? pc0 - 64'h1000 : pc0 + 64'h4, next_pc_out);
      end
      issue({7'h7f, 5'h1d, 5'd1, 3'h2, 5'b10001, 7'h7b}, 64'hfffffffffffffffd, 64'h0);
      flags(5'b00101);
      chk("next_pc", pc0 - 64'h10, next_pc_out);
      issue({7'h7f, 5'h1d, 5'd1, 3'h2, 5'b10001, 7'h7b}, 64'h1d, 64'h0);
      chk("next_pc", pc0 + 64'h4, next_pc_out);
      idle();
      $display("test branches done");
   endtask
   // byte scans, a bad rs2 field and a foreign opcode
   task automatic t_byte_ops;
      logic [63:0] vals [3] = '{64'h1122334400556677, 64'h1234000000000000, 64'h0};
      for (int i = 0; i < 3; i++)
      begin
         issue({7'h70, 5'd0, 5'd1, 3'h1, 5'd4, 7'h7b}, vals[i], 64'h0);
         flags(5'b01001);
         chk("mask", mask_of(vals[i]), wb_data_out);
         issue({7'h71, 5'd0, 5'd1, 3'h1, 5'd4, 7'h7b}, vals[i], 64'h0);
         chk("wb_rd", 64'h4, {59'h0, wb_rd_out});
         chk("first_nz", first_nz(vals[i]), wb_data_out);
      end
      issue({7'h70, 5'd1, 5'd1, 3'h1, 5'd4, 7'h7b}, 64'h1, 64'h0);
      flags(5'b00011);
      issue(32'h00000033, 64'h1, 64'h0);
      flags(5'b00000);
      idle();
      $display("test byte_ops done");
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // main sequence: reset for three cycles, released at a falling edge
   initial
   begin
      repeat (3) @(negedge clk_in);
      reset_in = 1'b0;
      t_post_store();
      t_gp_loads();
      t_gp_stores();
      t_branches();
      t_byte_ops();
      print_verdict();
   end
   // a hang counts as a mismatch and ends the run through the same report
   initial
   begin
      #200000;
      bad_count++;
      print_verdict();
   end
endmodule
